// ---- lbou_decode.sv ----
// Purpose: opcode decode into operation kind, length and cycle count
// Assumes: byte1 is the second instruction byte
// Notes: purely combinational
`timescale 1ns/1ps
module lbou_decode
(
	// instruction bytes
	input wire logic [7:0] i_opc,
	input wire logic [7:0] i_byte1,
	// decode results
	output lbou_pkg::lbou_op_t o_op,
	output logic [1:0] o_bytes,
	output logic [2:0] o_cycles,
	output logic o_src_pointer,
	output logic o_src_literal,
	output logic o_dst_work
);
	// opcode table
	always_comb
	begin
		o_op = lbou_pkg::LBOU_OP_NONE;
		o_bytes = lbou_pkg::BYTES_LONG;
		o_cycles = lbou_pkg::CYC_LONG;
		o_src_pointer = 1'b0;
		o_src_literal = 1'b0;
		o_dst_work = 1'b0;
		case (i_opc)
			lbou_pkg::OPC_AND_RR:
			begin
				o_op = lbou_pkg::LBOU_OP_AND;
				o_bytes = lbou_pkg::BYTES_SHORT;
				o_cycles = lbou_pkg::CYC_SHORT;
				o_dst_work = 1'b1;
			end
			lbou_pkg::OPC_AND_RIR:
			begin
				o_op = lbou_pkg::LBOU_OP_AND;
				o_bytes = lbou_pkg::BYTES_SHORT;
				o_dst_work = 1'b1;
				o_src_pointer = 1'b1;
			end
			lbou_pkg::OPC_AND_RRG:
				o_op = lbou_pkg::LBOU_OP_AND;
			lbou_pkg::OPC_AND_RPTR:
			begin
				o_op = lbou_pkg::LBOU_OP_AND;
				o_src_pointer = 1'b1;
			end
			lbou_pkg::OPC_AND_RLIT:
			begin
				o_op = lbou_pkg::LBOU_OP_AND;
				o_src_literal = 1'b1;
			end
			lbou_pkg::OPC_BAND:
				o_op = lbou_pkg::LBOU_OP_BAND;
			lbou_pkg::OPC_BCMP:
			begin
				// only the selector-0 form exists
				if (!i_byte1[lbou_pkg::FLD_SEL])
					o_op = lbou_pkg::LBOU_OP_BCMP;
			end
			lbou_pkg::OPC_BINV:
			begin
				if (!i_byte1[lbou_pkg::FLD_SEL])
				begin
					o_op = lbou_pkg::LBOU_OP_BINV;
					o_bytes = lbou_pkg::BYTES_SHORT;
					o_cycles = lbou_pkg::CYC_SHORT;
					o_dst_work = 1'b1;
				end
			end
			default:
				o_op = lbou_pkg::LBOU_OP_NONE;
		endcase
	end
endmodule : lbou_decode

// ---- lbou_pkg.sv ----
// Purpose: constants for the logic and bit operation unit
// Assumes: 8-bit core, flag byte laid out C Z S V D H in bits 7..2
// Notes: opcodes, byte and cycle counts, field positions
// Function
// - byte AND writes bitwise AND, source kept
// - byte AND: Z on zero, S=bit7, V cleared
// - byte AND opcodes 52..56, bytes and cycles
// - bit AND writes only one destination bit
// - bit AND: Z on zero bit, S cleared
// - bit AND opcode 67, LSB picks form
// - second byte: reg4, bit3, selector LSB
// - bit compare sets Z when bits equal
// - bit compare opcode 17, only LSB 0 form
// - zero flag lives in flag register D5
// - bit complement inverts only selected bit
// - bit complement opcode 57, Z on new bit
package lbou_pkg;
	// opcodes
	localparam logic [7:0] OPC_AND_RR = 8'h52;
	localparam logic [7:0] OPC_AND_RIR = 8'h53;
	localparam logic [7:0] OPC_AND_RRG = 8'h54;
	localparam logic [7:0] OPC_AND_RPTR = 8'h55;
	localparam logic [7:0] OPC_AND_RLIT = 8'h56;
	localparam logic [7:0] OPC_BAND = 8'h67;
	localparam logic [7:0] OPC_BCMP = 8'h17;
	localparam logic [7:0] OPC_BINV = 8'h57;
	// byte and cycle counts
	localparam logic [1:0] BYTES_SHORT = 2'h2;
	localparam logic [1:0] BYTES_LONG = 2'h3;
	localparam logic [2:0] CYC_SHORT = 3'h4;
	localparam logic [2:0] CYC_LONG = 3'h6;
	// flag register address and bit positions
	localparam logic [7:0] FLAG_REG_ADDR = 8'hd5;
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	// second byte fields
	localparam int FLD_REG_LSB = 4;
	localparam int FLD_BIT_LSB = 1;
	localparam int FLD_SEL = 0;
	// kinds of operation
	typedef enum logic [4:0] {
		LBOU_OP_NONE = 5'h01,
		LBOU_OP_AND = 5'h02,
		LBOU_OP_BAND = 5'h04,
		LBOU_OP_BCMP = 5'h08,
		LBOU_OP_BINV = 5'h10
	} lbou_op_t;
endpackage : lbou_pkg

// ---- lbou_unit.sv ----
// Purpose: execute byte AND, bit AND, bit compare and bit invert
// Assumes: core supplies operand values read from the register file
// Notes: one issue at a time; done pulses after the cycle count
`timescale 1ns/1ps
module lbou_unit
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// instruction issue
	input wire logic i_start,
	input wire logic [7:0] i_opc,
	input wire logic [7:0] i_byte1,
	input wire logic [7:0] i_byte2,
	// operand values read by the core
	input wire logic [7:0] i_dst_val,
	input wire logic [7:0] i_src_val,
	// flag register write from the core
	input wire logic i_flag_we,
	input wire logic [7:0] i_flag_wdata,
	// operand address requests
	output logic [7:0] o_dst_addr,
	output logic [7:0] o_src_addr,
	output logic o_src_pointer,
	output logic o_src_literal,
	// result write-back
	output logic o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	// flags and status
	output logic [7:0] o_flags,
	output logic [7:0] o_flag_addr,
	output logic [1:0] o_bytes,
	output logic o_busy,
	output logic o_done,
	output logic o_illegal
);
	// states
	typedef enum logic [1:0] {
		LBOU_ST_IDLE = 2'b01,
		LBOU_ST_RUN = 2'b10
	} lbou_state_t;

	lbou_state_t state; // controller state
	lbou_pkg::lbou_op_t dec_op; // decoded kind
	lbou_pkg::lbou_op_t op; // held kind
	logic [1:0] dec_bytes; // decoded length
	logic [2:0] dec_cycles; // decoded cycle count
	logic dec_ptr; // pointer source
	logic dec_lit; // literal source
	logic dec_work; // working-register destination
	logic [2:0] cnt; // cycles remaining
	logic [2:0] bitn; // bit number field
	logic sel; // form selector
	logic [7:0] dst_a; // next destination address
	logic [7:0] src_a; // next source address
	logic [7:0] next_res; // computed result
	logic next_we; // result is written
	logic next_z; // new zero flag
	logic finish; // last cycle

	// working register index maps to a register address
	function automatic logic [7:0] work_addr(input logic [3:0] r);
		work_addr = {4'h0, r};
	endfunction : work_addr

	lbou_decode u_decode
	(
		.i_opc(i_opc),
		.i_byte1(i_byte1),
		.o_op(dec_op),
		.o_bytes(dec_bytes),
		.o_cycles(dec_cycles),
		.o_src_pointer(dec_ptr),
		.o_src_literal(dec_lit),
		.o_dst_work(dec_work)
	);

	// operand address selection from instruction fields
	always_comb
	begin
		dst_a = i_byte2;
		src_a = i_byte1;
		case (dec_op)
			lbou_pkg::LBOU_OP_AND:
			begin
				if (dec_work)
				begin
					dst_a = work_addr(i_byte1[7:4]);
					src_a = work_addr(i_byte1[3:0]);
				end
				else if (dec_lit)
				begin
					dst_a = i_byte1;
					src_a = i_byte2;
				end
			end
			lbou_pkg::LBOU_OP_BAND, lbou_pkg::LBOU_OP_BCMP:
			begin
				// register field sits in the high nibble
				if (!i_byte1[lbou_pkg::FLD_SEL])
				begin
					dst_a = work_addr(i_byte1[7:lbou_pkg::FLD_REG_LSB]);
					src_a = i_byte2;
				end
				else
				begin
					dst_a = i_byte2;
					src_a = work_addr(i_byte1[7:lbou_pkg::FLD_REG_LSB]);
				end
			end
			lbou_pkg::LBOU_OP_BINV:
			begin
				dst_a = work_addr(i_byte1[7:lbou_pkg::FLD_REG_LSB]);
				src_a = dst_a;
			end
			default:
			begin
				dst_a = i_byte2;
				src_a = i_byte1;
			end
		endcase
	end

	// controller: issue, count cycles, finish
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state <= LBOU_ST_IDLE;
			cnt <= 3'h0;
			op <= lbou_pkg::LBOU_OP_NONE;
			bitn <= 3'h0;
			sel <= 1'b0;
			o_dst_addr <= 8'h00;
			o_src_addr <= 8'h00;
			o_src_pointer <= 1'b0;
			o_src_literal <= 1'b0;
			o_bytes <= 2'h0;
			o_busy <= 1'b0;
			o_illegal <= 1'b0;
		end
		else
		begin
			o_illegal <= 1'b0;
			case (state)
				LBOU_ST_IDLE:
				begin
					if (i_start && dec_op != lbou_pkg::LBOU_OP_NONE)
					begin
						state <= LBOU_ST_RUN;
						cnt <= dec_cycles - 3'h1;
						op <= dec_op;
						bitn <= i_byte1[3:lbou_pkg::FLD_BIT_LSB];
						sel <= i_byte1[lbou_pkg::FLD_SEL];
						o_dst_addr <= dst_a;
						o_src_addr <= src_a;
						o_src_pointer <= dec_ptr;
						o_src_literal <= dec_lit;
						o_bytes <= dec_bytes;
						o_busy <= 1'b1;
					end
					else if (i_start)
						o_illegal <= 1'b1;
				end
				LBOU_ST_RUN:
				begin
					cnt <= cnt - 3'h1;
					if (finish)
					begin
						state <= LBOU_ST_IDLE;
						o_busy <= 1'b0;
					end
				end
				default:
					state <= LBOU_ST_IDLE;
			endcase
		end
	end

	assign finish = (state == LBOU_ST_RUN) && (cnt == 3'h1);

	// result and zero flag computation
	always_comb
	begin
		next_res = i_dst_val;
		next_we = 1'b0;
		next_z = 1'b0;
		case (op)
			lbou_pkg::LBOU_OP_AND:
			begin
				next_res = i_dst_val & i_src_val;
				next_we = 1'b1;
				next_z = (next_res == 8'h00);
			end
			lbou_pkg::LBOU_OP_BAND:
			begin
				next_we = 1'b1;
				if (!sel)
					next_res[0] = i_dst_val[0] & i_src_val[bitn];
				else
					next_res[bitn] = i_dst_val[bitn] & i_src_val[0];
				next_z = !(sel ? next_res[bitn] : next_res[0]);
			end
			lbou_pkg::LBOU_OP_BCMP:
				next_z = (i_dst_val[0] == i_src_val[bitn]);
			lbou_pkg::LBOU_OP_BINV:
			begin
				next_res[bitn] = ~i_dst_val[bitn];
				next_we = 1'b1;
				next_z = !next_res[bitn];
			end
			default:
				next_we = 1'b0;
		endcase
	end

	// write-back port, one pulse at the end
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_wr_en <= 1'b0;
			o_wr_addr <= 8'h00;
			o_wr_data <= 8'h00;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= finish;
			o_wr_en <= finish && next_we;
			o_wr_addr <= o_dst_addr;
			o_wr_data <= next_res;
		end
	end

	// flag register; core writes lose to a finishing instruction
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_flags <= lbou_pkg::FLAG_RESET;
			o_flag_addr <= lbou_pkg::FLAG_REG_ADDR;
		end
		else if (finish)
		begin
			o_flag_addr <= lbou_pkg::FLAG_REG_ADDR;
			o_flags[lbou_pkg::FLAG_Z] <= next_z;
			if (op == lbou_pkg::LBOU_OP_AND)
			begin
				o_flags[lbou_pkg::FLAG_S] <= next_res[7];
				o_flags[lbou_pkg::FLAG_V] <= 1'b0;
			end
			else
				o_flags[lbou_pkg::FLAG_S] <= 1'b0;
			// V held for the bit forms
		end
		else if (i_flag_we)
			o_flags <= i_flag_wdata;
	end

	// byte AND result lands with the exact Z and S
	property p_and_flags;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(finish && op == lbou_pkg::LBOU_OP_AND) |=> (o_wr_en
			&& o_flags[lbou_pkg::FLAG_Z] == (o_wr_data == 8'h00)
			&& o_flags[lbou_pkg::FLAG_S] == o_wr_data[7]
			&& !o_flags[lbou_pkg::FLAG_V]);
	endproperty
	a_and_flags: assert property (p_and_flags) else $error("and flags");

	// register-register AND finishes four cycles after issue
	property p_short_len;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_start && !o_busy && i_opc == lbou_pkg::OPC_AND_RR)
		|=> o_busy [*3] ##1 !o_busy && o_done;
	endproperty
	a_short_len: assert property (p_short_len) else $error("cycles");

	// long forms take six cycles
	property p_long_len;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_start && !o_busy && i_opc == lbou_pkg::OPC_BAND)
		|=> o_busy [*5] ##1 o_done;
	endproperty
	a_long_len: assert property (p_long_len) else $error("cycles");

	// compare never writes an operand
	property p_cmp_nowrite;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(finish && op == lbou_pkg::LBOU_OP_BCMP) |=> !o_wr_en;
	endproperty
	a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("cmp wr");

	// invert changes exactly one bit
	property p_inv_onebit;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(finish && op == lbou_pkg::LBOU_OP_BINV)
		|=> $countones(o_wr_data ^ $past(i_dst_val)) == 1
		&& o_flags[lbou_pkg::FLAG_Z] == !o_wr_data[$past(bitn)];
	endproperty
	a_inv_onebit: assert property (p_inv_onebit) else $error("invert");

	// bit forms clear S and keep C and V
	property p_bit_flags;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(finish && op != lbou_pkg::LBOU_OP_AND)
		|=> !o_flags[lbou_pkg::FLAG_S]
		&& $stable(o_flags[lbou_pkg::FLAG_C])
		&& $stable(o_flags[lbou_pkg::FLAG_V]);
	endproperty
	a_bit_flags: assert property (p_bit_flags) else $error("bit flags");

	// bit AND touches at most one bit
	property p_band_one;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(finish && op == lbou_pkg::LBOU_OP_BAND)
		|=> $countones(o_wr_data ^ $past(i_dst_val)) <= 1;
	endproperty
	a_band_one: assert property (p_band_one) else $error("band");

	// compare with selector 1 is refused
	property p_cmp_form;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_start && !o_busy && i_opc == lbou_pkg::OPC_BCMP && i_byte1[0])
		|=> o_illegal && !o_busy;
	endproperty
	a_cmp_form: assert property (p_cmp_form) else $error("cmp form");
endmodule : lbou_unit

// ---- tb.sv ----
// Purpose: self-checking bench for the logic and bit operation unit
// Assumes: one issue at a time, operands held through each run
// Notes: the expected flag byte is kept in flags_m
`timescale 1ns/1ps
module tb;
	// clock, reset and issue
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_start = 1'b0;
	logic [7:0] i_opc = 8'h00;
	logic [7:0] i_byte1 = 8'h00;
	logic [7:0] i_byte2 = 8'h00;
	// operands and core flag write
	logic [7:0] i_dst_val = 8'h00;
	logic [7:0] i_src_val = 8'h00;
	logic i_flag_we = 1'b0;
	logic [7:0] i_flag_wdata = 8'h00;
	// design outputs
	logic [7:0] o_dst_addr, o_src_addr, o_wr_addr, o_wr_data;
	logic [7:0] o_flags, o_flag_addr;
	logic [1:0] o_bytes;
	logic o_src_pointer, o_src_literal, o_wr_en;
	logic o_busy, o_done, o_illegal;
	// bookkeeping
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] flags_m = 8'h00;

	lbou_unit DUT
	(
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_start(i_start),
		.i_opc(i_opc),
		.i_byte1(i_byte1),
		.i_byte2(i_byte2),
		.i_dst_val(i_dst_val),
		.i_src_val(i_src_val),
		.i_flag_we(i_flag_we),
		.i_flag_wdata(i_flag_wdata),
		.o_dst_addr(o_dst_addr),
		.o_src_addr(o_src_addr),
		.o_src_pointer(o_src_pointer),
		.o_src_literal(o_src_literal),
		.o_wr_en(o_wr_en),
		.o_wr_addr(o_wr_addr),
		.o_wr_data(o_wr_data),
		.o_flags(o_flags),
		.o_flag_addr(o_flag_addr),
		.o_bytes(o_bytes),
		.o_busy(o_busy),
		.o_done(o_done),
		.o_illegal(o_illegal)
	);

	// 200 MHz clock
	initial
	begin
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	// hang guard: far above the hundred or so cycles needed
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	// compare one value and count it
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// expected flags after a byte result
	function automatic void fbyte(input logic [7:0] r);
		flags_m = {flags_m[7], r == 8'h00, r[7], 1'b0, flags_m[3:0]};
	endfunction : fbyte

	// expected flags after a bit result, v kept
	function automatic void fbit(input logic b);
		flags_m = {flags_m[7], ~b, 1'b0, flags_m[4:0]};
	endfunction : fbit

	// issue one instruction and judge the finishing cycle
	task automatic run(input logic [7:0] opc, b1, b2, dv, sv,
		input int cyc, input logic we, input logic [7:0] wa, wd,
		input logic [1:0] nb);
		int n;
		@(posedge i_sys_clk);
		i_start <= 1'b1;
		i_opc <= opc;
		i_byte1 <= b1;
		i_byte2 <= b2;
		i_dst_val <= dv;
		i_src_val <= sv;
		@(posedge i_sys_clk);
		i_start <= 1'b0;
		// the cycle that carries the start strobe counts as the first
		n = 1;
		do
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		while (o_done !== 1'b1 && n < 20);
		chk("cycles", 8'(n), 8'(cyc));
		chk("wr_en", {7'h0, o_wr_en}, {7'h0, we});
		chk("dst_addr", o_dst_addr, wa);
		chk("busy", {7'h0, o_busy}, 8'h00);
		if (we)
		begin
			chk("wr_addr", o_wr_addr, wa);
			chk("wr_data", o_wr_data, wd);
		end
		chk("flags", o_flags, flags_m);
		chk("bytes", {6'h0, o_bytes}, {6'h0, nb});
	endtask : run

	// issue a refused instruction, expect the illegal pulse only
	task automatic bad(input logic [7:0] opc, b1);
		logic seen;
		seen = 1'b0;
		@(posedge i_sys_clk);
		i_start <= 1'b1;
		i_opc <= opc;
		i_byte1 <= b1;
		@(posedge i_sys_clk);
		i_start <= 1'b0;
		// the pulse stands only in the cycle right after the issue edge
		repeat (3)
		begin
			#1;
			seen = seen | (o_illegal === 1'b1);
			@(posedge i_sys_clk);
		end
		#1;
		chk("illegal", {7'h0, seen}, 8'h01);
		chk("busy", {7'h0, o_busy}, 8'h00);
		chk("flags", o_flags, flags_m);
	endtask : bad

	// core writes the flag byte; c, z, v, d and h set
	task automatic t_flag();
		@(posedge i_sys_clk);
		i_flag_we <= 1'b1;
		i_flag_wdata <= 8'hdc;
		@(posedge i_sys_clk);
		i_flag_we <= 1'b0;
		@(posedge i_sys_clk);
		#1;
		flags_m = 8'hdc;
		chk("flags", o_flags, flags_m);
		$display("test flag write done");
	endtask : t_flag

	// bit and, bit compare and bit invert
	task automatic t_bits();
		fbit(1'b0);
		run(8'h67, 8'h12, 8'h01, 8'h07, 8'h05, 6, 1, 8'h01, 8'h06, 3);
		fbit(1'b1);
		run(8'h67, 8'h12, 8'h01, 8'h07, 8'h07, 6, 1, 8'h01, 8'h07, 3);
		fbit(1'b0);
		run(8'h67, 8'h15, 8'h40, 8'h04, 8'h04, 6, 1, 8'h40, 8'h00, 3);
		// differing bits clear z, equal bits set it
		fbit(1'b1);
		run(8'h17, 8'h12, 8'h01, 8'h07, 8'h01, 6, 0, 8'h01, 8'h00, 3);
		fbit(1'b0);
		run(8'h17, 8'h12, 8'h01, 8'h07, 8'h03, 6, 0, 8'h01, 8'h00, 3);
		bad(8'h17, 8'h13);
		fbit(1'b0);
		run(8'h57, 8'h12, 8'h00, 8'h07, 8'h00, 4, 1, 8'h01, 8'h05, 2);
		fbit(1'b1);
		run(8'h57, 8'h1e, 8'h00, 8'h07, 8'h00, 4, 1, 8'h01, 8'h87, 2);
		bad(8'h57, 8'h13);
		$display("test bit ops done");
	endtask : t_bits

	// byte and in all five operand forms
	task automatic t_and();
		fbyte(8'h02);
		run(8'h52, 8'h12, 8'h00, 8'h12, 8'h03, 4, 1, 8'h01, 8'h02, 2);
		chk("src_addr", o_src_addr, 8'h02);
		fbyte(8'h80);
		run(8'h53, 8'h12, 8'h00, 8'h80, 8'hf0, 6, 1, 8'h01, 8'h80, 2);
		chk("pointer", {7'h0, o_src_pointer}, 8'h01);
		fbyte(8'h00);
		run(8'h54, 8'h20, 8'h30, 8'h21, 8'h0a, 6, 1, 8'h30, 8'h00, 3);
		chk("src_addr", o_src_addr, 8'h20);
		fbyte(8'h5a);
		run(8'h55, 8'h20, 8'h30, 8'hff, 8'h5a, 6, 1, 8'h30, 8'h5a, 3);
		fbyte(8'h21);
		run(8'h56, 8'h01, 8'h25, 8'h21, 8'h25, 6, 1, 8'h01, 8'h21, 3);
		chk("literal", {7'h0, o_src_literal}, 8'h01);
		bad(8'hff, 8'h00);
		$display("test byte and done");
	endtask : t_and

	// verdict and end of run
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// main sequence
	initial
	begin
		repeat (3) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		#1;
		chk("flags", o_flags, 8'h00);
		chk("flag_addr", o_flag_addr, 8'hd5);
		chk("busy", {7'h0, o_busy}, 8'h00);
		$display("test reset done");
		t_flag();
		t_bits();
		t_flag();
		t_and();
		end_of_test();
	end
endmodule : tb
